// ### stack_substack_pkg.sv
// Shared constants for the substack partitioning block
package stack_substack_pkg;

    // ---------------------------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [11:0] PTR_OFFSET    = 12'h000;
    localparam logic [11:0] UFL_OFFSET    = 12'h004;
    localparam logic [11:0] OFL_OFFSET    = 12'h008;
    localparam logic [11:0] STATUS_OFFSET = 12'h00c;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int PS_LSB       = 0;
    localparam int RS_LSB       = 8;
    localparam int PS_START_BIT = 0;
    localparam int RS_START_BIT = 8;
    localparam int PS_SIZE_LSB  = 1;
    localparam int RS_SIZE_LSB  = 9;
    localparam int PS_FATAL_BIT = 0;
    localparam int RS_FATAL_BIT = 1;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [15:0] UFL_RESET = 16'h0000;
    localparam logic [15:0] OFL_RESET = 16'h0000;

    // ---------------------------------------------------------------
    // Substack size selection
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SIZE_256 = 2'b00,
        SIZE_128 = 2'b01,
        SIZE_64  = 2'b10,
        SIZE_32  = 2'b11
    } size_sel_t;

    localparam logic [7:0] MASK_256 = 8'hff;
    localparam logic [7:0] MASK_128 = 8'h7f;
    localparam logic [7:0] MASK_64  = 8'h3f;
    localparam logic [7:0] MASK_32  = 8'h1f;

endpackage

// ### stack_substack_config.sv
// Substack partitioning and pointer logic for both hardware stacks
// Summary of operation
// - A 256-entry stack runs whole or as 8x32, 4x64 or 2x128 substacks.
// - Underflow limit bits 2:1 (parameter) and 10:9 (return) pick the size.
// - In a substack the upper pointer bits are its number and stay fixed.
// - Start flags are underflow limit bit 0 (parameter) and bit 8 (return).
// - Start flag one makes the stack begin at location zero of the substack.
// - Start flag zero makes the stack begin at the substack midpoint.
// - An overflow limit below the midpoint forces a start at the bottom.
// - Push writes at ptr plus the start offset then increments; pop reads one below that then decrements.
// - Stacks and substacks wrap circularly at both ends.
// - An error stays set until software writes the pointer register.
// - Both pointers clear to zero at reset.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module stack_unit
    import stack_substack_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // Configuration
    input  wire logic [1:0] size_i,
    input  wire logic       start_i,
    input  wire logic [7:0] ovf_lim_i,
    // Pointer load from software
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    // Core operations
    input  wire logic       push_i,
    input  wire logic       pop_i,
    // Results
    output logic [7:0]      ptr_o,
    output logic [7:0]      addr_o,
    output logic            we_o,
    output logic            re_o,
    output logic            fatal_o
);

    logic [7:0] mask;
    logic [7:0] half;
    logic [7:0] start_off;
    logic [7:0] base;
    logic [7:0] off;
    logic [7:0] ph;
    logic       low_lim;
    logic       do_push;
    logic       do_pop;
    logic       fatal_evt;
    logic [7:0] ptr_nxt;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    always_comb begin
        case (size_sel_t'(size_i))
            SIZE_256: mask = MASK_256;
            SIZE_128: mask = MASK_128;
            SIZE_64:  mask = MASK_64;
            SIZE_32:  mask = MASK_32;
            default:  mask = MASK_256;
        endcase
    end

    assign half    = (mask >> 1) + 8'h01;
    // Limit inside the substack decides whether the midpoint is usable
    assign low_lim = (ovf_lim_i & mask) < half;
    assign start_off = (start_i || low_lim) ? 8'h00 : half;

    // Config is read live, so a write lands before the next operation
    assign base = ptr_o & ~mask;
    assign off  = ptr_o & mask;
    assign ph   = (off + start_off) & mask;

    // Push has priority; a pointer write beats both
    assign do_push = push_i && !wr_i;
    assign do_pop  = pop_i && !push_i && !wr_i;

    // Touching the top cell of the substack corrupts data
    assign fatal_evt = (do_push && ph == mask) ||
                       (do_pop && ph == 8'h00);

    always_comb begin
        ptr_nxt = ptr_o;
        if (wr_i) begin
            ptr_nxt = wdata_i;
        end else if (do_push) begin
            ptr_nxt = base | ((off + 8'h01) & mask);
        end else if (do_pop) begin
            ptr_nxt = base | ((off - 8'h01) & mask);
        end
    end

    // ---------------------------------------------------------------
    // Pointer
    // ---------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_o <= PTR_RESET[7:0];
        end else begin
            ptr_o <= ptr_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Memory access
    // ---------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_o <= 8'h00;
            we_o   <= 1'b0;
            re_o   <= 1'b0;
        end else begin
            we_o <= do_push;
            re_o <= do_pop;
            if (do_push) begin
                addr_o <= base | ph;
            end else if (do_pop) begin
                addr_o <= base | ((ph - 8'h01) & mask);
            end
        end
    end

    // ---------------------------------------------------------------
    // Error flag
    // ---------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fatal_o <= 1'b0;
        end else if (fatal_evt) begin
            fatal_o <= 1'b1;
        end else if (wr_i) begin
            fatal_o <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_push_step: assert property (
        do_push |=> ((ptr_o - $past(ptr_o)) & $past(mask)) == 8'h01)
        else $error("push did not advance pointer");

    a_pop_step: assert property (
        do_pop |=> ((ptr_o - $past(ptr_o)) & $past(mask)) ==
                   $past(mask))
        else $error("pop did not step pointer back");

    a_sub_fixed: assert property (
        (do_push || do_pop) |=>
            (ptr_o & ~$past(mask)) == $past(base))
        else $error("substack number changed");

    a_pop_wrap: assert property (
        do_pop && ph == 8'h00 |=> re_o && addr_o == ($past(base) |
            $past(mask)))
        else $error("pop did not wrap to top");

    a_start_bottom: assert property (
        do_push && start_i && off == 8'h00 |=>
            we_o && (addr_o & $past(mask)) == 8'h00)
        else $error("start flag one not at bottom");

    a_start_mid: assert property (
        do_push && !start_i && !low_lim && off == 8'h00 |=>
            (addr_o & $past(mask)) == $past(half))
        else $error("start flag zero not at midpoint");

    a_low_limit: assert property (
        do_push && low_lim && off == 8'h00 |=>
            (addr_o & $past(mask)) == 8'h00)
        else $error("low limit did not force bottom");

    a_fatal_hold: assert property (
        fatal_o && !wr_i |=> fatal_o)
        else $error("error flag dropped without write");

    a_ptr_write: assert property (
        wr_i && !fatal_evt |=> ptr_o == $past(wdata_i) && !fatal_o)
        else $error("pointer write not taken");

endmodule

module stack_substack_config
    import stack_substack_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Parameter stack operations
    input  wire logic        ps_push_i,
    input  wire logic        ps_pop_i,
    output logic [7:0]       ps_addr_o,
    output logic             ps_we_o,
    output logic             ps_re_o,
    // Return stack operations
    input  wire logic        rs_push_i,
    input  wire logic        rs_pop_i,
    output logic [7:0]       rs_addr_o,
    output logic             rs_we_o,
    output logic             rs_re_o,
    // Error flags
    output logic             ps_fatal_o,
    output logic             rs_fatal_o
);

    logic [15:0] stack_underflow_limit_reg_r;
    logic [15:0] stack_overflow_limit_reg_r;
    logic [7:0]  ps_ptr;
    logic [7:0]  rs_ptr;
    logic        setup;
    logic        access;
    logic        wr_ptr;
    logic        mapped;
    logic [31:0] rdata_nxt;

    assign setup  = psel_i && !penable_i;
    assign access = psel_i && penable_i && pready_o;
    assign wr_ptr = access && pwrite_i && paddr_i == PTR_OFFSET;
    assign mapped = paddr_i == PTR_OFFSET || paddr_i == UFL_OFFSET ||
                    paddr_i == OFL_OFFSET || paddr_i == STATUS_OFFSET;

    // ---------------------------------------------------------------
    // APB handshake
    // ---------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (paddr_i)
            PTR_OFFSET:    rdata_nxt[15:0] = {rs_ptr, ps_ptr};
            UFL_OFFSET:    rdata_nxt[15:0] = stack_underflow_limit_reg_r;
            OFL_OFFSET:    rdata_nxt[15:0] = stack_overflow_limit_reg_r;
            STATUS_OFFSET: rdata_nxt[1:0]  = {rs_fatal_o, ps_fatal_o};
            default:       rdata_nxt = 32'h0000_0000;
        endcase
    end

    // One wait-free access phase: data is captured during setup
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup && !mapped;
            if (setup && !pwrite_i) begin
                prdata_o <= rdata_nxt;
            end
        end
    end

    // ---------------------------------------------------------------
    // Limit registers
    // ---------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stack_underflow_limit_reg_r <= UFL_RESET;
            stack_overflow_limit_reg_r  <= OFL_RESET;
        end else if (access && pwrite_i) begin
            if (paddr_i == UFL_OFFSET) begin
                stack_underflow_limit_reg_r <= pwdata_i[15:0];
            end
            if (paddr_i == OFL_OFFSET) begin
                stack_overflow_limit_reg_r <= pwdata_i[15:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Stacks
    // ---------------------------------------------------------------
    stack_unit u_ps (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .size_i    (stack_underflow_limit_reg_r[PS_SIZE_LSB +: 2]),
        .start_i   (stack_underflow_limit_reg_r[PS_START_BIT]),
        .ovf_lim_i (stack_overflow_limit_reg_r[PS_LSB +: 8]),
        .wr_i      (wr_ptr),
        .wdata_i   (pwdata_i[PS_LSB +: 8]),
        .push_i    (ps_push_i),
        .pop_i     (ps_pop_i),
        .ptr_o     (ps_ptr),
        .addr_o    (ps_addr_o),
        .we_o      (ps_we_o),
        .re_o      (ps_re_o),
        .fatal_o   (ps_fatal_o)
    );

    stack_unit u_rs (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .size_i    (stack_underflow_limit_reg_r[RS_SIZE_LSB +: 2]),
        .start_i   (stack_underflow_limit_reg_r[RS_START_BIT]),
        .ovf_lim_i (stack_overflow_limit_reg_r[RS_LSB +: 8]),
        .wr_i      (wr_ptr),
        .wdata_i   (pwdata_i[RS_LSB +: 8]),
        .push_i    (rs_push_i),
        .pop_i     (rs_pop_i),
        .ptr_o     (rs_ptr),
        .addr_o    (rs_addr_o),
        .we_o      (rs_we_o),
        .re_o      (rs_re_o),
        .fatal_o   (rs_fatal_o)
    );

    a_reset_ptrs: assert property (
        @(posedge clock_i) $rose(rst_n_i) |-> ps_ptr == 8'h00 &&
            rs_ptr == 8'h00)
        else $error("pointers not cleared by reset");

endmodule

`default_nettype wire

// ### stack_core_model.sv
// Processor core model issuing push and pop pulses to both stacks
`timescale 1ns/10ps
`default_nettype none

module stack_core_model (
    // Clock
    input  wire logic       clock_i,
    // Operation requests
    output logic            ps_push_o,
    output logic            ps_pop_o,
    output logic            rs_push_o,
    output logic            rs_pop_o,
    // Results from the stack block
    input  wire logic [7:0] ps_addr_i,
    input  wire logic       ps_we_i,
    input  wire logic       ps_re_i,
    input  wire logic [7:0] rs_addr_i,
    input  wire logic       rs_we_i,
    input  wire logic       rs_re_i
);
    initial begin
        ps_push_o = 1'b0;
        ps_pop_o  = 1'b0;
        rs_push_o = 1'b0;
        rs_pop_o  = 1'b0;
    end

    // ---------------------------------------------------------------
    // One operation: a single-cycle pulse, result sampled once settled
    // ---------------------------------------------------------------
    task automatic op(input logic s, input logic push,
                      output logic [7:0] addr, output logic hit);
        @(posedge clock_i);
        if (s) begin
            rs_push_o <= push;
            rs_pop_o  <= !push;
        end else begin
            ps_push_o <= push;
            ps_pop_o  <= !push;
        end
        @(posedge clock_i);
        ps_push_o <= 1'b0;
        ps_pop_o  <= 1'b0;
        rs_push_o <= 1'b0;
        rs_pop_o  <= 1'b0;
        // Wait past the edge so the registered answer has landed
        #1;
        addr = s ? rs_addr_i : ps_addr_i;
        hit  = s ? (push ? rs_we_i : rs_re_i) : (push ? ps_we_i : ps_re_i);
    endtask
endmodule
`default_nettype wire

// ### stack_substack_config_bench.sv
// Self-checking bench for the substack partitioning block
`timescale 1ns/10ps
`default_nettype none

module stack_substack_config_bench;
    import stack_substack_pkg::*;

    logic        clock_i;
    logic        rst_n_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ps_push, ps_pop, rs_push, rs_pop;
    logic [7:0]  ps_addr, rs_addr;
    logic        ps_we, ps_re, rs_we, rs_re;
    logic        ps_fatal, rs_fatal;
    int          num_errors;
    int          tests_run;
    logic [31:0] q;
    logic        e;
    logic [7:0]  a, mask, half, base;
    logic        hit;
    int          sh;

    stack_substack_config u_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .ps_push_i(ps_push), .ps_pop_i(ps_pop), .ps_addr_o(ps_addr),
        .ps_we_o(ps_we), .ps_re_o(ps_re),
        .rs_push_i(rs_push), .rs_pop_i(rs_pop), .rs_addr_o(rs_addr),
        .rs_we_o(rs_we), .rs_re_o(rs_re),
        .ps_fatal_o(ps_fatal), .rs_fatal_o(rs_fatal)
    );

    stack_core_model u_core (
        .clock_i(clock_i),
        .ps_push_o(ps_push), .ps_pop_o(ps_pop),
        .rs_push_o(rs_push), .rs_pop_o(rs_pop),
        .ps_addr_i(ps_addr), .ps_we_i(ps_we), .ps_re_i(ps_re),
        .rs_addr_i(rs_addr), .rs_we_i(rs_we), .rs_re_i(rs_re)
    );

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // ---------------------------------------------------------------
    // Bus and compare tasks
    // ---------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        @(posedge clock_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge clock_i);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Bound well above the roughly 380 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clock_i);
        num_errors++;
        wrap_up;
    end

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        num_errors = 0;
        tests_run  = 0;
        rst_n_i    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h0;
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        apb(1'b0, PTR_OFFSET, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, UFL_OFFSET, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(q, 32'h0);
        // Unmapped place must refuse with an error and zero data
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(e), 32'h1);
        chk(q, 32'h0);
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 4; c++) begin
                mask = 8'hff >> c;
                half = (mask >> 1) + 8'h01;
                base = ~mask;
                sh   = 8 * s;
                apb(1'b1, OFL_OFFSET, 32'h0000ffff);
                apb(1'b1, UFL_OFFSET, 32'({c[1:0], 1'b0}) << sh);
                apb(1'b1, PTR_OFFSET, 32'(base) << sh);
                u_core.op(s[0], 1'b1, a, hit);
                chk(32'(a), 32'(base | half));
                chk(32'(hit), 32'h1);
                u_core.op(s[0], 1'b0, a, hit);
                chk(32'(a), 32'(base | half));
                chk(32'(hit), 32'h1);
                apb(1'b1, OFL_OFFSET, 32'h0);
                apb(1'b1, PTR_OFFSET, 32'(base) << sh);
                u_core.op(s[0], 1'b1, a, hit);
                chk(32'(a), 32'(base));
                apb(1'b1, UFL_OFFSET, 32'({c[1:0], 1'b1}) << sh);
                apb(1'b1, PTR_OFFSET, 32'(base | mask) << sh);
                u_core.op(s[0], 1'b1, a, hit);
                chk(32'(a), 32'(base | mask));
                apb(1'b0, PTR_OFFSET, 32'h0);
                chk(q, 32'(base) << sh);
                apb(1'b0, STATUS_OFFSET, 32'h0);
                chk(q, 32'h1 << s);
                u_core.op(s[0], 1'b0, a, hit);
                chk(32'(a), 32'(base | mask));
                chk(32'(s ? rs_fatal : ps_fatal), 32'h1);
                apb(1'b1, PTR_OFFSET, 32'(base) << sh);
                apb(1'b0, STATUS_OFFSET, 32'h0);
                chk(q, 32'h0);
                // First push from the substack bottom with start flag one
                u_core.op(s[0], 1'b1, a, hit);
                chk(32'(a), 32'(base));
            end
        end
        wrap_up;
    end
endmodule
`default_nettype wire
